//--- src/smb_rd_cfg.svh
/*
  Constants for the two-wire read-protocol engine: command codes, the
  register space bounds, fixed-block command range and bus timing counts.
  Assumes a 25 MHz system clock on both ends.
*/
`ifndef SMB_RD_CFG_SVH
`define SMB_RD_CFG_SVH
`define CMD_BLK_WR        8'hF0
`define CMD_BLK_RD        8'hF1
`define CMD_FIX_FIRST     8'hF2
`define CMD_FIX_LAST      8'hFD
`define REG_TOP           8'hEF
`define ADDR_TOP          8'hFF
`define BLK_WR_COUNT      8'h02
`define DEV_ADDR          7'h2C
`define CLK_MHZ           25
`define SCL_HALF_NS       1250
`define SCL_HALF_CYC      ((`SCL_HALF_NS * `CLK_MHZ) / 1000)
`endif

//--- src/smb_rd_pkg.sv
/*
  Types shared by both ends of the read-protocol link.
  Assumes the constants header is available by include path.
*/
package smb_rd_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {op_byte, op_word, op_block} op_t;
endpackage : smb_rd_pkg

//--- src/smb_link_if.sv
/*
  Two-wire link between master end and slave end. Both lines are
  open drain; the wire level is low when any driver enables low.
  Assumes the bench instantiates it and adds pull-ups implicitly.
*/
interface smb_link_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (output scl_oe_m, output sda_oe_m,
                  input scl, input sda);
  modport slave (output sda_oe_s, input scl, input sda);
endinterface : smb_link_if

//--- src/smb_rd_slave.sv
/*
  Slave end: decodes write/read transactions, serves register reads,
  block process calls (native and two-step), fixed blocks, and keeps
  block-write pointer bookkeeping. Register storage is a local array.
  Assumes a master on the link and a single 25 MHz clock.
*/
`include "smb_rd_cfg.svh"
module smb_rd_slave
  import smb_rd_pkg::*;
(
  input  wire logic   i_mclk,
  input  wire logic   i_rst_n,
  smb_link_if.slave   link,
  input  wire logic   i_wr_en,
  input  wire byte_t  i_wr_addr,
  input  wire byte_t  i_wr_data,
  output byte_t       o_base,
  output logic        o_busy
);
  import smb_rd_pkg::*;
  typedef enum {s_idle, s_addr, s_addr_ack, s_wbyte, s_wack,
                s_rbyte, s_rack} st_t;
  st_t         st;
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic        scl_q;
  logic        sda_q;
  logic [2:0]  bit_cnt;
  byte_t       sh;
  logic        rd_dir;
  logic [2:0]  widx;
  byte_t       cmd;
  byte_t       base;
  byte_t       ptr;
  byte_t       blk_len;
  byte_t       cnt_left;
  logic        cnt_phase;
  logic        blk_mode;
  byte_t       frz_hi;
  logic        frz_valid;
  logic        sda_oe;
  logic        seen_rise;
  byte_t       regs [0:255];
  byte_t       fx_addr;
  byte_t       fx_size;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  byte_t       rdata;
  // two-flop synchronisers; the second stage and a one-cycle delayed copy of it are read
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  assign scl_rise = scl_s[1] & ~scl_q;
  assign scl_fall = ~scl_s[1] & scl_q;
  assign start_c  = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  // fixed-block lookup table
  always_comb
  begin
    unique case (cmd[3:0])
      4'h2: begin fx_addr = 8'h40; fx_size = 8'h08; end
      4'h3: begin fx_addr = 8'h48; fx_size = 8'h08; end
      4'h4: begin fx_addr = 8'h50; fx_size = 8'h06; end
      4'h5: begin fx_addr = 8'h56; fx_size = 8'h10; end
      4'h6: begin fx_addr = 8'h67; fx_size = 8'h04; end
      4'h7: begin fx_addr = 8'h6E; fx_size = 8'h08; end
      4'h8: begin fx_addr = 8'h78; fx_size = 8'h0C; end
      4'h9: begin fx_addr = 8'h90; fx_size = 8'h20; end
      4'hA: begin fx_addr = 8'hB4; fx_size = 8'h08; end
      4'hB: begin fx_addr = 8'hC8; fx_size = 8'h08; end
      4'hC: begin fx_addr = 8'hD0; fx_size = 8'h10; end
      4'hD: begin fx_addr = 8'hE5; fx_size = 8'h09; end
      default: begin fx_addr = 8'h00; fx_size = 8'h00; end
    endcase
  end
  // data byte for the current read pointer
  always_comb
  begin
    if (ptr > `REG_TOP)
      rdata = 8'h00;
    else if (frz_valid && ptr[0])
      rdata = frz_hi;
    else
      rdata = regs[ptr];
  end
  // register array: user port loads, block writes update in range
  always_ff @(posedge i_mclk)
  begin
    if (i_wr_en)
      regs[i_wr_addr] <= i_wr_data;
    else if (st == s_wack && scl_fall && cmd == `CMD_BLK_WR
             && widx > 3'd2 && ptr <= `REG_TOP)
      regs[ptr] <= sh;
  end
  // protocol engine
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      st <= s_idle;
      bit_cnt <= 3'd0;
      sh <= 8'h00;
      rd_dir <= 1'b0;
      widx <= 3'd0;
      cmd <= 8'h00;
      base <= 8'h00;
      ptr <= 8'h00;
      blk_len <= 8'h01;
      cnt_left <= 8'h00;
      cnt_phase <= 1'b0;
      blk_mode <= 1'b0;
      frz_hi <= 8'h00;
      frz_valid <= 1'b0;
      sda_oe <= 1'b0;
      seen_rise <= 1'b0;
    end
    else if (start_c)
    begin
      st <= s_addr;
      bit_cnt <= 3'd0;
      sda_oe <= 1'b0;
      seen_rise <= 1'b0;
    end
    else if (stop_c)
    begin
      st <= s_idle;
      sda_oe <= 1'b0;
    end
    else
    begin
      unique case (st)
        s_idle: sda_oe <= 1'b0;
        s_addr, s_wbyte:
          if (scl_rise)
          begin
            sh <= {sh[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 3'd1;
            seen_rise <= 1'b1;
          end
          // the clock fall that closes a start carries no bit yet
          else if (scl_fall && bit_cnt == 3'd0 && seen_rise)
          begin
            if (st == s_addr)
            begin
              if (sh[7:1] == `DEV_ADDR)
              begin
                sda_oe <= 1'b1;
                rd_dir <= sh[0];
                st <= s_addr_ack;
                if (!sh[0])
                  widx <= 3'd0;
              end
              else
                st <= s_idle;
            end
            else
            begin
              sda_oe <= 1'b1;
              st <= s_wack;
              if (widx == 3'd0)
                cmd <= sh;
              else if (cmd == `CMD_BLK_RD && widx == 3'd2)
                base <= sh;
              else if (cmd == `CMD_BLK_RD && widx == 3'd3)
                blk_len <= sh;
              else if (cmd == `CMD_BLK_WR && widx == 3'd2)
                ptr <= sh;
              if (widx == 3'd0 && sh < `CMD_BLK_WR)
                base <= sh;
            end
          end
        s_addr_ack:
          if (scl_fall)
          begin
            bit_cnt <= 3'd0;
            if (rd_dir)
            begin
              st <= s_rbyte;
              blk_mode <= (cmd >= `CMD_BLK_RD);
              cnt_phase <= (cmd >= `CMD_BLK_RD);
              if (cmd >= `CMD_FIX_FIRST && cmd <= `CMD_FIX_LAST)
              begin
                ptr <= fx_addr;
                sh <= fx_size;
              end
              else if (cmd == `CMD_BLK_RD)
              begin
                ptr <= base;
                sh <= blk_len;
              end
              else
              begin
                ptr <= base;
                sh <= (base > `REG_TOP) ? 8'h00 :
                      ((frz_valid && base[0]) ? frz_hi : regs[base]);
                if (base <= `REG_TOP && !base[0])
                begin
                  frz_hi <= regs[base + 8'h01];
                  frz_valid <= 1'b1;
                end
              end
              sda_oe <= 1'b0;
            end
            else
            begin
              st <= s_wbyte;
              sda_oe <= 1'b0;
            end
          end
        s_wack:
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 3'd0;
            st <= s_wbyte;
            if (widx != 3'd7)
              widx <= widx + 3'd1;
            if (cmd == `CMD_BLK_WR && widx > 3'd2
                && ptr != `ADDR_TOP)
              ptr <= ptr + 8'h01;
          end
        s_rbyte:
          if (scl_fall)
          begin
            if (bit_cnt == 3'd7)
            begin
              sda_oe <= 1'b0;                          // master acks
              st <= s_rack;
            end
            else
            begin
              sda_oe <= ~sh[3'd6 - bit_cnt];
              bit_cnt <= bit_cnt + 3'd1;
            end
          end
          else if (bit_cnt == 3'd0 && !scl_s[1])
            sda_oe <= ~sh[7];
        // next byte starts only after the fall closing the ack bit
        s_rack:
          if (scl_fall)
          begin
            st <= s_rbyte;
            bit_cnt <= 3'd0;
          end
          else if (scl_rise)
          begin
            if (sda_s[1])
              st <= s_idle;
            else
            begin
              if (cnt_phase)
                cnt_phase <= 1'b0;
              else if (ptr != `ADDR_TOP)
                ptr <= ptr + 8'h01;
              if (!cnt_phase && ptr[0] && frz_valid)
                frz_valid <= 1'b0;
              if (!cnt_phase && ptr != `ADDR_TOP)
                sh <= (ptr + 8'h01 > `REG_TOP) ? 8'h00 :
                      regs[ptr + 8'h01];
              else
                sh <= rdata;
            end
            if (blk_mode && !cnt_phase)
              base <= (ptr == `ADDR_TOP) ? ptr :
                      ptr + 8'h01;
            if (!blk_mode && sda_s[1] && ptr[0])
              frz_valid <= 1'b0;
          end
      endcase
    end
  assign link.sda_oe_s = sda_oe;
  // status to the user side
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_base <= 8'h00;
      o_busy <= 1'b0;
    end
    else
    begin
      o_base <= base;
      o_busy <= (st != s_idle);
    end
endmodule : smb_rd_slave

//--- src/smb_rd_master.sv
/*
  Master end: runs read byte, read word and block read transactions
  (native, fixed-code or the second step of the emulation) on demand.
  Assumes the slave end on the link and a single 25 MHz clock.
*/
`include "smb_rd_cfg.svh"
module smb_rd_master
  import smb_rd_pkg::*;
(
  input  wire logic   i_mclk,
  input  wire logic   i_rst_n,
  smb_link_if.master  link,
  input  wire logic   i_go,
  input  wire op_t    i_op,
  input  wire byte_t  i_cmd,
  input  wire byte_t  i_start,
  input  wire byte_t  i_len,
  input  wire logic   i_native,
  output byte_t       o_data,
  output logic        o_valid,
  output logic        o_done
);
  import smb_rd_pkg::*;
  typedef enum {m_idle, m_start, m_bit, m_ack, m_rstart,
                m_stop} mst_t;
  mst_t        st;
  logic [15:0] tick;
  logic [1:0]  ph;
  logic [2:0]  bit_cnt;
  byte_t       wq [0:5];
  logic [2:0]  wn;
  logic [2:0]  wi;
  logic        reading;
  byte_t       rx;
  byte_t       rleft;
  logic        scl_oe;
  logic        sda_oe;
  logic [1:0]  sda_s;
  logic        step;
  assign step = (tick == 16'(`SCL_HALF_CYC));
  // sampled data line, two flops since it crosses from a pin
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
      sda_s <= 2'h3;
    else
      sda_s <= {sda_s[0], link.sda};
  // quarter-bit phase timer
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
      tick <= 16'h0000;
    else
      tick <= (step || st == m_idle) ? 16'h0000 : tick + 16'h0001;
  // sequencer; each bit has four phases of quarter-bit time
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      st <= m_idle; ph <= 2'd0; bit_cnt <= 3'd0; wn <= 3'd0;
      wi <= 3'd0; reading <= 1'b0; rx <= 8'h00; rleft <= 8'h00;
      scl_oe <= 1'b0; sda_oe <= 1'b0;
      o_data <= 8'h00; o_valid <= 1'b0; o_done <= 1'b0;
      for (int k = 0; k < 6; k++) wq[k] <= 8'h00;
    end
    else
    begin
      o_valid <= 1'b0;
      o_done <= 1'b0;
      if (st == m_idle && i_go)
      begin
        wq[0] <= {`DEV_ADDR, 1'b0};
        wq[1] <= i_cmd;
        wq[2] <= `BLK_WR_COUNT;
        wq[3] <= i_start;
        wq[4] <= i_len;
        wn <= (i_op == op_block && i_native) ? 3'd5 : 3'd2;
        rleft <= (i_op == op_byte) ? 8'h01 :
                 (i_op == op_word) ? 8'h02 : 8'hFF;
        wi <= 3'd0; reading <= 1'b0; ph <= 2'd0;
        sda_oe <= 1'b1; st <= m_start;
      end
      else if (st != m_idle && step)
      begin
        ph <= ph + 2'd1;
        unique case (st)
          m_start: if (ph == 2'd1) begin scl_oe <= 1'b1; st <= m_bit;
                   bit_cnt <= 3'd7; ph <= 2'd0; end
          m_bit:
            unique case (ph)
              2'd0: sda_oe <= reading ? 1'b0 : ~wq[wi][bit_cnt];
              2'd1: scl_oe <= 1'b0;
              2'd2: rx <= {rx[6:0], sda_s[1]};
              2'd3:
              begin
                scl_oe <= 1'b1;
                if (bit_cnt == 3'd0) st <= m_ack;
                else bit_cnt <= bit_cnt - 3'd1;
              end
            endcase
          m_ack:
            unique case (ph)
              2'd0: sda_oe <= reading && rleft != 8'h01;
              2'd1: scl_oe <= 1'b0;
              2'd2: if (reading)
                    begin
                      o_data <= rx; o_valid <= 1'b1;
                      if (rleft == 8'hFF) rleft <= rx; // count byte
                      else rleft <= rleft - 8'h01;
                    end
              2'd3:
              begin
                scl_oe <= 1'b1; bit_cnt <= 3'd7;
                if (reading && rleft == 8'h00) st <= m_stop;
                else if (!reading && wi + 3'd1 == wn)
                  st <= m_rstart;
                else if (!reading && wi == 3'd5) st <= m_bit;
                else begin st <= m_bit; if (!reading) wi <= wi + 3'd1; end
              end
            endcase
          m_rstart:
            unique case (ph)
              2'd0: sda_oe <= 1'b0;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b1;
              2'd3:
              begin
                scl_oe <= 1'b1; wq[5] <= {`DEV_ADDR, 1'b1};
                wi <= 3'd5; st <= m_bit; ph <= 2'd0;
              end
            endcase
          m_stop:
            unique case (ph)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b0;
              2'd3: begin st <= m_idle; o_done <= 1'b1; end
            endcase
          default: st <= m_idle;
        endcase
        if (st == m_ack && ph == 2'd3 && wi == 3'd5 && !reading)
          reading <= 1'b1;
      end
    end
  assign link.scl_oe_m = scl_oe;
  assign link.sda_oe_m = sda_oe;
endmodule : smb_rd_master

//--- tb/smb_rd_checker.sv
/*
  Protocol checker for the two-wire read link: clock phase lengths,
  slave data stability while the clock is high, and bus release by the slave.
  Assumes it watches the interface joining both ends, on one clock.
*/
module smb_rd_checker
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // start and stop are data edges while the clock line stays high
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  // each clock phase lasts far longer than a few system cycles
  property p_scl_high_min;
    $rose(scl) |=> scl [*8];
  endproperty
  a_scl_high_min: assert property (p_scl_high_min)
    else $error("clock high phase too short");

  property p_scl_low_min;
    $fell(scl) |=> !scl [*8];
  endproperty
  a_scl_low_min: assert property (p_scl_low_min)
    else $error("clock low phase too short");

  // no stretching exists, so a low phase must end in bounded time
  property p_scl_low_max;
    $fell(scl) |-> ##[1:400] scl;
  endproperty
  a_scl_low_max: assert property (p_scl_low_max)
    else $error("clock held low too long");

  // slave data may only move while the clock is low
  property p_slave_stable_high;
    scl && $past(scl) |-> $stable(sda_oe_s);
  endproperty
  a_slave_stable_high: assert property (p_slave_stable_high)
    else $error("slave data changed with clock high");

  // while the clock is high only one end may pull the data line
  property p_no_clash_high;
    scl |-> !(sda_oe_s && sda_oe_m);
  endproperty
  a_no_clash_high: assert property (p_no_clash_high)
    else $error("both ends drive data with clock high");

  // for eight cycles after a stop the slave keeps off the bus
  property p_stop_release;
    s_stop |=> !sda_oe_s [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("slave drives data after stop");

  property p_start_release;
    s_start |-> !sda_oe_s;
  endproperty
  a_start_release: assert property (p_start_release)
    else $error("slave drives data during start");

  // reset leaves every open-drain line released
  property p_reset_release;
    $rose(i_rst_n) |-> !sda_oe_s && !sda_oe_m && !scl_oe_m;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("link not released after reset");

  c_stop: cover property (s_stop);
endmodule : smb_rd_checker

//--- tb/tb_top.sv
/*
  Self-checking bench joining master and slave ends over the link.
  Assumes the register array loads through the slave's write port
  and reads are launched through the master's request port.
*/
module tb_top;
  import smb_rd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    op_t         op;
    byte_t       cmd;
    byte_t       start;
    byte_t       len;
    logic        nat;
    int          n;
    logic [39:0] exp;
    byte_t       base;
  } row_t;

  logic  i_mclk;
  logic  i_rst_n;
  logic  i_go;
  op_t   i_op;
  byte_t i_cmd;
  byte_t i_start;
  byte_t i_len;
  logic  i_native;
  logic  i_wr_en;
  byte_t i_wr_addr;
  byte_t i_wr_data;
  byte_t o_data;
  logic  o_valid;
  logic  o_done;
  byte_t o_base;
  logic  o_busy;
  int    checked;
  int    miscompares;
  byte_t got[$];

  // register contents are address xor 5Ah, so a wrap shows as 5Ah
  row_t rows [6] = '{
    '{op_byte, 8'h10, 8'h00, 8'h00, 1'b0, 1, 40'h4A00000000, 8'h10},
    '{op_word, 8'h20, 8'h00, 8'h00, 1'b0, 2, 40'h7A7B000000, 8'h20},
    '{op_block, 8'hF1, 8'hEC, 8'h02, 1'b1, 3, 40'h02B6B70000, 8'hEE},
    // two-step second half; bench is the only master
    '{op_block, 8'hF1, 8'h00, 8'h00, 1'b0, 3, 40'h02B4B50000, 8'hF0},
    '{op_block, 8'hF6, 8'h00, 8'h00, 1'b0, 5, 40'h043D323330, 8'h6B},
    '{op_block, 8'hF1, 8'hFE, 8'h03, 1'b1, 4, 40'h0300000000, 8'hFF}
  };

  smb_link_if link ();

  smb_rd_master u_smb_rd_master (
    .i_mclk   (i_mclk),
    .i_rst_n  (i_rst_n),
    .link     (link),
    .i_go     (i_go),
    .i_op     (i_op),
    .i_cmd    (i_cmd),
    .i_start  (i_start),
    .i_len    (i_len),
    .i_native (i_native),
    .o_data   (o_data),
    .o_valid  (o_valid),
    .o_done   (o_done)
  );

  smb_rd_slave u_smb_rd_slave (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .link      (link),
    .i_wr_en   (i_wr_en),
    .i_wr_addr (i_wr_addr),
    .i_wr_data (i_wr_data),
    .o_base    (o_base),
    .o_busy    (o_busy)
  );

  smb_rd_checker u_smb_rd_checker (
    .i_mclk   (i_mclk),
    .i_rst_n  (i_rst_n),
    .scl_oe_m (link.scl_oe_m),
    .sda_oe_m (link.sda_oe_m),
    .sda_oe_s (link.sda_oe_s),
    .scl      (link.scl),
    .sda      (link.sda)
  );

  // 25 MHz system clock
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // every received byte is kept in order for the current test
  always @(negedge i_mclk)
    if (o_valid === 1'b1)
      got.push_back(o_data);

  // inputs move a fixed 2 ns after the edge to stay clear of sampling
  task automatic tick;
    @(posedge i_mclk);
    #2;
  endtask : tick

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // one transaction, bounded wait for completion
  task automatic run(input row_t r);
    int k;
    got.delete();
    i_op = r.op;
    i_cmd = r.cmd;
    i_start = r.start;
    i_len = r.len;
    i_native = r.nat;
    i_go = 1'b1;
    tick;
    i_go = 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 30000)
    begin
      tick;
      k++;
    end
    check("done", 8'h01, {7'h00, o_done});
    tick;
  endtask : run

  // a hang anywhere ends the run with a mismatch; the tests need
  // about 50000 cycles, so this leaves a wide margin
  initial
  begin
    repeat (80000) @(posedge i_mclk);
    miscompares++;
    give_verdict;
  end

  initial
  begin
    checked = 0;
    miscompares = 0;
    i_rst_n = 1'b0;
    i_go = 1'b0;
    i_op = op_byte;
    i_cmd = 8'h00;
    i_start = 8'h00;
    i_len = 8'h00;
    i_native = 1'b0;
    i_wr_en = 1'b0;
    i_wr_addr = 8'h00;
    i_wr_data = 8'h00;
    repeat (16) tick;
    i_rst_n = 1'b1;
    // load every address; those above the register space are stored but read back as 00
    for (int a = 0; a < 256; a++)
    begin
      i_wr_en = 1'b1;
      i_wr_addr = 8'(a);
      i_wr_data = 8'(a) ^ 8'h5A;
      tick;
    end
    i_wr_en = 1'b0;
    tick;
    for (int i = 0; i < 6; i++)
    begin
      run(rows[i]);
      check("count", rows[i].n[7:0], 8'(got.size()));
      for (int j = 0; j < rows[i].n; j++)
        check("data", rows[i].exp[39-8*j -: 8], got[j]);
      check("base", rows[i].base, o_base);
      $display("test %0d finished", i);
    end
    // reset in mid-transfer must drop everything and free the bus
    i_cmd = 8'h10;
    i_op = op_byte;
    i_native = 1'b0;
    i_go = 1'b1;
    tick;
    i_go = 1'b0;
    repeat (500) tick;
    i_rst_n = 1'b0;
    repeat (2) tick;
    check("busy", 8'h00, {7'h00, o_busy});
    check("valid", 8'h00, {7'h00, o_valid});
    check("base", 8'h00, o_base);
    check("scl", 8'h01, {7'h00, link.scl});
    check("sda", 8'h01, {7'h00, link.sda});
    i_rst_n = 1'b1;
    repeat (4) tick;
    check("idle", 8'h00, {7'h00, o_busy});
    $display("test reset finished");
    give_verdict;
  end
endmodule : tb_top
